// ==== hw/eesl_slave.sv ====
`timescale 1ns/100ps
// Contract
// - supply reset holds logic; release means standby
// - sample on clock rise, drive after fall
// - floating strap pin reads as low
// - write-protect high blocks all memory writes; code samples it before first data only
// - START/STOP by data edge; idle until START
// - match type code and three strap levels
// - last address bit selects read or write
// - ninth clock carries acknowledge from receiver
// - byte write acknowledged byte by byte
// - STOP after data starts write; no ACK meanwhile
// - up to 32 bytes fill page buffer
// - page fixed, low address wraps within page
// - whole page committed in one write cycle
// - protect sampled before first data, then NAK
// - memory starts with every byte FFh
// - read sends byte at current address
// - sequential read continues while master acknowledges
// - read address wraps at end of memory
module eesl_slave #(
   parameter int WRITE_CYCLES = eesl_pkg::INTERNAL_WRITE_CYCLES
) (
   input  wire logic                      clk_sys_i,
   input  wire logic                      rst_i,
   input  wire eesl_pkg::eesl_bus_in_type bus_i,
   input  wire eesl_pkg::eesl_strap_type  strap_i,
   input  wire logic                      write_protect_i,
   output eesl_pkg::eesl_bus_out_type     bus_o,
   output logic                           write_busy_o
);
   import eesl_pkg::*;

   eesl_regs_type     st_reg;
   eesl_regs_type     st_next;
   logic [7:0]        mem_reg  [0:MEM_BYTES-1];
   logic [7:0]        pbuf_reg [0:PAGE_BYTES-1];
   logic              pbuf_we;
   logic [PAGE_W-1:0] pbuf_idx;
   logic              commit_we;
   logic [PAGE_W-1:0] commit_idx;
   logic [7:0]        mem_rd;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_ev;
   logic              stop_ev;
   logic              byte_done;
   logic              dev_match;

   // Shipped erased
   initial begin
      for (int i = 0; i < MEM_BYTES; i++) begin
         mem_reg[i] = ERASED_BYTE;
      end
   end

   assign scl_rise   = st_reg.scl_s & ~st_reg.scl_p;
   assign scl_fall   = ~st_reg.scl_s & st_reg.scl_p;
   assign start_ev   = st_reg.scl_s & st_reg.scl_p & st_reg.sda_p & ~st_reg.sda_s;
   assign stop_ev    = st_reg.scl_s & st_reg.scl_p & ~st_reg.sda_p & st_reg.sda_s;
   assign byte_done  = scl_fall && (st_reg.bitcnt == BITS_PER_BYTE);
   assign dev_match  = (st_reg.shreg[7:4] == DEV_TYPE_CODE)
                       && (st_reg.shreg[3:1] == st_reg.strap_s)
                       && !st_reg.busy;
   assign commit_idx = st_reg.timer[PAGE_W-1:0];
   assign commit_we  = st_reg.busy && (st_reg.timer < TIMER_W'(PAGE_BYTES))
                       && st_reg.pmask[commit_idx];
   assign mem_rd     = mem_reg[st_reg.addr];

   always_comb begin
      st_next  = st_reg;
      pbuf_we  = 1'b0;
      pbuf_idx = st_reg.addr[PAGE_W-1:0];
      // Two-stage synchronisers; data bits are taken on rise, START/STOP are seen while the clock is high
      st_next.scl_m   = bus_i.scl;
      st_next.scl_s   = st_reg.scl_m;
      st_next.scl_p   = st_reg.scl_s;
      st_next.sda_m   = bus_i.sda;
      st_next.sda_s   = st_reg.sda_m;
      st_next.sda_p   = st_reg.sda_s;
      // Straps and protect are pulled low outside when left open
      st_next.strap_m = {strap_i.select_strap_bit2, strap_i.select_strap_bit1,
                         strap_i.select_strap_bit0};
      st_next.strap_s = st_reg.strap_m;
      st_next.wp_m    = write_protect_i;
      st_next.wp_s    = st_reg.wp_m;
      st_next.bus.sda = 1'b0;

      // Internal write cycle: page is copied while the timer runs
      if (st_reg.busy) begin
         st_next.timer = st_reg.timer + 1'b1;
         if (st_reg.timer == TIMER_W'(WRITE_CYCLES - 1)) begin
            st_next.busy  = 1'b0;
            st_next.pmask = '0;
         end
      end

      if (start_ev) begin
         st_next.state      = ST_DEVSEL;
         st_next.bitcnt     = 4'h0;
         st_next.bus.sda_oe = 1'b0;
         if (!st_reg.busy) begin
            st_next.pmask = '0;
         end
      end else if (stop_ev) begin
         if (st_reg.state == ST_WDATA && st_reg.pmask != '0 && !st_reg.busy
             && !st_reg.wp_lat) begin
            st_next.busy  = 1'b1;
            st_next.timer = '0;
         end
         st_next.state      = ST_IDLE;
         st_next.bus.sda_oe = 1'b0;
      end else begin
         case (st_reg.state)
            ST_DEVSEL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA: begin
               if (scl_rise && st_reg.bitcnt != BITS_PER_BYTE) begin
                  st_next.shreg  = {st_reg.shreg[6:0], st_reg.sda_s};
                  st_next.bitcnt = st_reg.bitcnt + 1'b1;
               end
               if (byte_done) begin
                  st_next.bitcnt     = 4'h0;
                  st_next.state      = ST_ACK;
                  st_next.bus.sda_oe = 1'b1;
                  if (st_reg.state == ST_DEVSEL) begin
                     if (!dev_match) begin
                        st_next.state      = ST_IGNORE;
                        st_next.bus.sda_oe = 1'b0;
                     end else if (st_reg.shreg[0] == DIR_READ) begin
                        st_next.ret = ST_TX;
                     end else begin
                        st_next.ret = ST_ADDR_HI;
                     end
                  end else if (st_reg.state == ST_ADDR_HI) begin
                     st_next.addr[ADDR_W-1:8] = st_reg.shreg[ADDR_W-9:0];
                     st_next.ret              = ST_ADDR_LO;
                  end else if (st_reg.state == ST_ADDR_LO) begin
                     st_next.addr[7:0] = st_reg.shreg;
                     st_next.ret       = ST_WDATA;
                  end else if (st_reg.wp_lat) begin
                     st_next.state      = ST_IGNORE;
                     st_next.bus.sda_oe = 1'b0;
                     st_next.pmask      = '0;
                  end else begin
                     pbuf_we                        = 1'b1;
                     st_next.pmask[pbuf_idx]        = 1'b1;
                     st_next.addr[PAGE_W-1:0]       = st_reg.addr[PAGE_W-1:0] + 1'b1;
                     st_next.ret                    = ST_WDATA;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  st_next.bus.sda_oe = 1'b0;
                  st_next.state      = st_reg.ret;
                  if (st_reg.ret == ST_WDATA && st_reg.pmask == '0) begin
                     st_next.wp_lat = st_reg.wp_s;
                  end
                  if (st_reg.ret == ST_TX) begin
                     st_next.shreg      = mem_rd;
                     st_next.bus.sda_oe = ~mem_rd[7];
                     st_next.bitcnt     = 4'h1;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (st_reg.bitcnt == BITS_PER_BYTE) begin
                     st_next.bus.sda_oe = 1'b0;
                     st_next.addr       = st_reg.addr + 1'b1;
                     st_next.state      = ST_TX_ACK;
                  end else begin
                     st_next.bus.sda_oe = ~st_reg.shreg[6];
                     st_next.shreg      = {st_reg.shreg[6:0], 1'b0};
                     st_next.bitcnt     = st_reg.bitcnt + 1'b1;
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  st_next.state = st_reg.sda_s ? ST_IGNORE : ST_TX_WAIT;
               end
            end
            ST_TX_WAIT: begin
               if (scl_fall) begin
                  st_next.shreg      = mem_rd;
                  st_next.bus.sda_oe = ~mem_rd[7];
                  st_next.bitcnt     = 4'h1;
                  st_next.state      = ST_TX;
               end
            end
            default: begin
               st_next.bus.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // Supply-level reset; release lands in standby
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg <= REGS_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (pbuf_we) begin
         pbuf_reg[pbuf_idx] <= st_reg.shreg;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (commit_we) begin
         mem_reg[{st_reg.addr[ADDR_W-1:PAGE_W], commit_idx}] <= pbuf_reg[commit_idx];
      end
   end

   assign bus_o        = st_reg.bus;
   assign write_busy_o = st_reg.busy;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   oe_only_drive_a: assert property (st_reg.bus.sda_oe |->
      (st_reg.state == ST_ACK || st_reg.state == ST_TX))
      else $error("data driven outside ack or transmit");
   busy_no_ack_a: assert property (st_reg.busy |-> st_reg.state != ST_ACK)
      else $error("acknowledge given during write cycle");
   start_devsel_a: assert property (start_ev |=>
      (st_reg.state == ST_DEVSEL && st_reg.bitcnt == 4'h0 && !st_reg.bus.sda_oe))
      else $error("start did not open address phase");
   stop_idle_a: assert property (stop_ev && !start_ev |=> st_reg.state == ST_IDLE)
      else $error("stop did not return to standby");
   wrong_type_nak_a: assert property (st_reg.state == ST_DEVSEL && byte_done
      && st_reg.shreg[7:4] != DEV_TYPE_CODE |=> st_reg.state == ST_IGNORE
      ##1 !st_reg.bus.sda_oe)
      else $error("foreign address acknowledged");
   wp_reject_a: assert property (st_reg.state == ST_WDATA && byte_done
      && st_reg.wp_lat && !start_ev && !stop_ev |=> st_reg.state == ST_IGNORE
      && st_reg.pmask == '0)
      else $error("protected write not rejected");
   wp_no_load_a: assert property (st_reg.wp_lat |-> !pbuf_we)
      else $error("page loaded while protected");
   busy_hold_a: assert property ($rose(st_reg.busy) |-> st_reg.busy [*8])
      else $error("write cycle ended early");
   page_wrap_a: assert property (pbuf_we && !start_ev && !stop_ev |=>
      st_reg.addr[ADDR_W-1:PAGE_W] == $past(st_reg.addr[ADDR_W-1:PAGE_W])
      && st_reg.addr[PAGE_W-1:0] == $past(st_reg.addr[PAGE_W-1:0]) + 5'h1)
      else $error("page address not held or offset not stepped");
   read_step_a: assert property (st_reg.state == ST_TX && byte_done
      && !start_ev && !stop_ev |=> st_reg.addr == $past(st_reg.addr) + 12'h001)
      else $error("read address not advanced");

   // Write cycle length follows the timer, so a short count shows up here
   busy_length_a: assert property ($fell(st_reg.busy) |->
      $past(st_reg.timer) == TIMER_W'(WRITE_CYCLES - 1)
      && st_reg.pmask == '0)
      else $error("write cycle length wrong");

   busy_float_a: assert property (st_reg.busy |->
      !st_reg.bus.sda_oe && st_reg.state != ST_TX)
      else $error("data driven during write cycle");

   stop_launch_a: assert property (stop_ev && st_reg.state == ST_WDATA
      && st_reg.pmask != '0 && !st_reg.busy && !st_reg.wp_lat
      |=> st_reg.busy && st_reg.timer == '0)
      else $error("stop after data did not start write");

   idle_until_start_a: assert property (st_reg.state == ST_IDLE && !start_ev
      |=> st_reg.state == ST_IDLE)
      else $error("left standby without start");

   dev_ack_go_a: assert property (st_reg.state == ST_DEVSEL && byte_done
      && dev_match
      |=> st_reg.state == ST_ACK && st_reg.bus.sda_oe)
      else $error("matching address not acknowledged");

   strap_miss_a: assert property (st_reg.state == ST_DEVSEL && byte_done
      && st_reg.shreg[3:1] != st_reg.strap_s |=> st_reg.state == ST_IGNORE)
      else $error("address with other strap levels accepted");

   ignore_quiet_a: assert property (st_reg.state == ST_IGNORE |->
      !st_reg.bus.sda_oe)
      else $error("ignored transfer drives data");

   shift_in_a: assert property (scl_rise && st_reg.bitcnt != BITS_PER_BYTE
      && (st_reg.state == ST_DEVSEL || st_reg.state == ST_WDATA)
      |=> st_reg.shreg[0] == $past(st_reg.sda_s))
      else $error("data bit not taken on clock rise");

   addr_hi_take_a: assert property (st_reg.state == ST_ADDR_HI && byte_done
      |=> st_reg.addr[ADDR_W-1:8] == $past(st_reg.shreg[ADDR_W-9:0])
      && st_reg.state == ST_ACK)
      else $error("high address bits not taken");

   addr_lo_take_a: assert property (st_reg.state == ST_ADDR_LO && byte_done
      |=> st_reg.addr[7:0] == $past(st_reg.shreg)
      && st_reg.state == ST_ACK)
      else $error("low address byte not taken");

   data_ack_a: assert property (st_reg.state == ST_WDATA && byte_done
      && !st_reg.wp_lat |=> st_reg.state == ST_ACK && st_reg.bus.sda_oe)
      else $error("data byte not acknowledged");

   ack_release_a: assert property (st_reg.state == ST_ACK && scl_fall
      && st_reg.ret != ST_TX |=> !st_reg.bus.sda_oe)
      else $error("acknowledge held past ninth clock");

   tx_first_bit_a: assert property (st_reg.state == ST_ACK && scl_fall
      && st_reg.ret == ST_TX |=> st_reg.state == ST_TX
      && st_reg.bus.sda_oe == !$past(mem_rd[7]))
      else $error("first read bit not driven");

   tx_shift_a: assert property (st_reg.state == ST_TX && scl_fall
      && st_reg.bitcnt != BITS_PER_BYTE
      |=> st_reg.bus.sda_oe == !$past(st_reg.shreg[6]))
      else $error("read bit not driven after clock fall");

   tx_release_a: assert property (st_reg.state == ST_TX && byte_done
      |=> st_reg.state == ST_TX_ACK && !st_reg.bus.sda_oe)
      else $error("data line not released for master acknowledge");

   read_nak_end_a: assert property (st_reg.state == ST_TX_ACK && scl_rise
      && st_reg.sda_s |=> st_reg.state == ST_IGNORE)
      else $error("read went on after master refusal");

   read_go_on_a: assert property (st_reg.state == ST_TX_ACK && scl_rise
      && !st_reg.sda_s |=> st_reg.state == ST_TX_WAIT)
      else $error("read stopped after master acknowledge");

   wp_strobe_a: assert property (st_reg.state == ST_ACK && scl_fall
      && st_reg.ret == ST_WDATA && st_reg.pmask == '0
      |=> st_reg.wp_lat == $past(st_reg.wp_s))
      else $error("protect level not strobed before first data");

   wp_block_a: assert property (st_reg.wp_lat && st_reg.state == ST_WDATA
      |-> st_reg.pmask == '0)
      else $error("protected session holds loaded bytes");

   dev_ack_c: cover property (st_reg.state == ST_DEVSEL && byte_done && dev_match);
   write_go_c: cover property ($rose(st_reg.busy));
   seq_read_c: cover property (st_reg.state == ST_TX_WAIT ##[1:1000] st_reg.state == ST_TX);
   wp_hit_c: cover property (st_reg.state == ST_WDATA && byte_done && st_reg.wp_lat);

endmodule

// ==== hw/eesl_pkg.sv ====
package eesl_pkg;

   localparam int MEM_BYTES          = 4096;
   localparam int ADDR_W             = 12;
   localparam int PAGE_BYTES         = 32;
   localparam int PAGE_W             = 5;
   localparam int CLK_PERIOD_NS      = 5;
   localparam int INTERNAL_WRITE_TIME_NS = 5000000;
   // Longest write time rounds down to whole cycles
   localparam int INTERNAL_WRITE_CYCLES  = INTERNAL_WRITE_TIME_NS / CLK_PERIOD_NS;
   localparam int TIMER_W            = 20;

   localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
   localparam logic [7:0] ERASED_BYTE   = 8'hFF;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic       DIR_READ      = 1'b1;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0000,
      ST_DEVSEL  = 4'b0001,
      ST_ADDR_HI = 4'b0010,
      ST_ADDR_LO = 4'b0011,
      ST_WDATA   = 4'b0100,
      ST_ACK     = 4'b0101,
      ST_TX      = 4'b0110,
      ST_TX_ACK  = 4'b0111,
      ST_TX_WAIT = 4'b1000,
      ST_IGNORE  = 4'b1001
   } eesl_state_type;

   typedef struct packed {
      logic scl;
      logic sda;
   } eesl_bus_in_type;

   typedef struct packed {
      logic sda;
      logic sda_oe;
   } eesl_bus_out_type;

   typedef struct packed {
      logic select_strap_bit2;
      logic select_strap_bit1;
      logic select_strap_bit0;
   } eesl_strap_type;

   typedef struct packed {
      logic                    scl_m;
      logic                    scl_s;
      logic                    scl_p;
      logic                    sda_m;
      logic                    sda_s;
      logic                    sda_p;
      logic [2:0]              strap_m;
      logic [2:0]              strap_s;
      logic                    wp_m;
      logic                    wp_s;
      eesl_state_type          state;
      eesl_state_type          ret;
      logic [3:0]              bitcnt;
      logic [7:0]              shreg;
      logic [ADDR_W-1:0]       addr;
      logic [PAGE_BYTES-1:0]   pmask;
      logic                    wp_lat;
      logic                    busy;
      logic [TIMER_W-1:0]      timer;
      eesl_bus_out_type        bus;
   } eesl_regs_type;

   localparam eesl_regs_type REGS_RESET = '{
      scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
      sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
      strap_m: 3'h0, strap_s: 3'h0, wp_m: 1'b0, wp_s: 1'b0,
      state: ST_IDLE, ret: ST_IDLE, bitcnt: 4'h0, shreg: 8'h00,
      addr: 12'h000, pmask: 32'h0000_0000, wp_lat: 1'b0, busy: 1'b0,
      timer: 20'h0_0000, bus: '{sda: 1'b0, sda_oe: 1'b0}
   };

endpackage

// ==== test/eesl_master.sv ====
`timescale 1ns/100ps
module eesl_master (
   output logic      scl_o,
   output logic      sda_oe_o,
   input  wire logic sda_i
);
   localparam realtime QTR = 16.0;
   initial begin
      scl_o    = 1'b1;
      sda_oe_o = 1'b0;
   end
   // Data changes only while the clock is low; sampled in mid-high
   task automatic bit_io(input logic b, output logic r);
      sda_oe_o = ~b;
      #QTR scl_o = 1'b1;
      #QTR r = sda_i;
      #QTR scl_o = 1'b0;
      #QTR;
   endtask
   task automatic start_cond();
      sda_oe_o = 1'b0;
      #QTR scl_o = 1'b1;
      #QTR sda_oe_o = 1'b1;
      #QTR scl_o = 1'b0;
      #QTR;
   endtask
   // Clock is left high afterwards: it stands still between frames
   task automatic stop_cond();
      sda_oe_o = 1'b1;
      #QTR scl_o = 1'b1;
      #QTR sda_oe_o = 1'b0;
      #(2 * QTR);
   endtask
   // A receiving master passes 8'hFF so the line stays released
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                       output logic ack_out);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(ack_in, ack_out);
   endtask
endmodule

// ==== test/eesl_slave_tb_top.sv ====
`timescale 1ns/100ps
module eesl_slave_tb_top;
   import eesl_pkg::*;
   localparam int         WCYC  = 400;
   localparam logic [2:0] STRAP = 3'h5;
   logic             clk_sys_i = 1'b0;
   logic             rst_i     = 1'b1;
   logic             prot      = 1'b0;
   logic             scl;
   logic             m_oe;
   logic             busy;
   eesl_bus_in_type  bus_i;
   eesl_bus_out_type bus_o;
   eesl_strap_type   strap_i   = 3'h0;
   int               err_total   = 0;
   int               check_count = 0;
   logic [7:0]       q;
   logic             a;
   assign bus_i = '{scl: scl, sda: ~(m_oe | bus_o.sda_oe)};
   always #2.5 clk_sys_i = ~clk_sys_i;
   eesl_master i_eesl_master (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(bus_i.sda));
   eesl_slave #(.WRITE_CYCLES(WCYC)) i_eesl_slave (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .bus_i(bus_i), .strap_i(strap_i), .write_protect_i(prot), .bus_o(bus_o),
      .write_busy_o(busy));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (err_total == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(bus_o.sda_oe) begin
      if (!rst_i) begin
         chk(8'({scl, bus_o.sda}), 8'h00);
      end
   end
   task automatic put(input logic [7:0] d, input logic exp);
      i_eesl_master.xfer(d, 1'b1, q, a);
      chk(8'(a), 8'(exp));
   endtask
   task automatic get(input logic ack_in, input logic [7:0] exp);
      i_eesl_master.xfer(8'hFF, ack_in, q, a);
      chk(q, exp);
      chk(8'(a), 8'(ack_in));
   endtask
   task automatic set_addr(input logic [15:0] ad);
      i_eesl_master.start_cond();
      put({DEV_TYPE_CODE, STRAP, 1'b0}, 1'b0);
      put(ad[15:8], 1'b0);
      put(ad[7:0], 1'b0);
   endtask
   task automatic rd_start();
      i_eesl_master.start_cond();
      put({DEV_TYPE_CODE, STRAP, 1'b1}, 1'b0);
   endtask
   // Poll with bare write selects until the device answers again
   task automatic finish_write(input logic exp_busy);
      i_eesl_master.stop_cond();
      #1;
      chk(8'(busy), 8'(exp_busy));
      a = 1'b1;
      for (int n = 0; n < 20 && a !== 1'b0; n++) begin
         i_eesl_master.start_cond();
         i_eesl_master.xfer({DEV_TYPE_CODE, STRAP, 1'b0}, 1'b1, q, a);
         i_eesl_master.stop_cond();
         if (n == 0) begin
            chk(8'(a), 8'(exp_busy));
         end
      end
      if (a !== 1'b0) begin
         err_total++;
         close_out();
      end
      chk(8'(busy), 8'h00);
   endtask
   task automatic t_nostart();
      i_eesl_master.xfer({DEV_TYPE_CODE, STRAP, 1'b0}, 1'b1, q, a);
      chk(8'(a), 8'h01);
   endtask
   task automatic t_select();
      i_eesl_master.start_cond();
      put({DEV_TYPE_CODE ^ 4'h1, STRAP, 1'b0}, 1'b1);
      i_eesl_master.start_cond();
      put({DEV_TYPE_CODE, STRAP ^ 3'h4, 1'b0}, 1'b1);
      i_eesl_master.stop_cond();
   endtask
   task automatic t_erased();
      set_addr(16'hF123);
      rd_start();
      get(1'b1, ERASED_BYTE);
      i_eesl_master.stop_cond();
   endtask
   task automatic t_byte_write();
      set_addr(16'hF000);
      put(8'h3C, 1'b0);
      finish_write(1'b1);
   endtask
   task automatic t_wrap_read();
      set_addr(16'h0FFF);
      rd_start();
      get(1'b1, ERASED_BYTE);
      i_eesl_master.stop_cond();
      rd_start();
      get(1'b0, 8'h3C);
      get(1'b1, ERASED_BYTE);
      i_eesl_master.stop_cond();
   endtask
   // 34 bytes from page offset 30: the last two land on the first two again
   task automatic t_page();
      set_addr(16'h00FE);
      for (int k = 0; k < 34; k++) begin
         put(8'(k), 1'b0);
      end
      finish_write(1'b1);
      set_addr(16'h00E0);
      rd_start();
      for (int o = 0; o < 32; o++) begin
         get(1'b0, 8'(o + 2));
      end
      get(1'b1, ERASED_BYTE);
      i_eesl_master.stop_cond();
   endtask
   task automatic t_protect();
      @(posedge clk_sys_i) #1 prot = 1'b1;
      set_addr(16'h0010);
      put(8'h77, 1'b1);
      finish_write(1'b0);
      @(posedge clk_sys_i) #1 prot = 1'b0;
      set_addr(16'h0010);
      rd_start();
      get(1'b1, ERASED_BYTE);
      i_eesl_master.stop_cond();
   endtask
   task automatic t_reset();
      set_addr(16'h0000);
      put(8'h99, 1'b0);
      @(posedge clk_sys_i) #1 rst_i = 1'b1;
      #2;
      chk(8'({bus_o.sda_oe, busy}), 8'h00);
      repeat (4) @(posedge clk_sys_i);
      #1 rst_i = 1'b0;
      i_eesl_master.stop_cond();
      chk(8'(busy), 8'h00);
      set_addr(16'h0000);
      rd_start();
      get(1'b1, 8'h3C);
      i_eesl_master.stop_cond();
   endtask
   initial begin
      repeat (16) @(posedge clk_sys_i);
      #1 rst_i = 1'b0;
      strap_i = STRAP;
      repeat (8) @(posedge clk_sys_i);
      t_nostart();
      t_select();
      t_erased();
      t_byte_write();
      t_wrap_read();
      t_page();
      t_protect();
      t_reset();
      close_out();
   end
endmodule
